/* core/sda_synth_ctrl.sv */
/*
 * Synthesizer deviation, offset, AFC and rate control with byte registers.
 * Assumes a same-clock register port and demodulator.
 */
// Operation
// R1 - nine-bit deviation word, 625 Hz steps
// R2 - deviation step independent of band
// R3 - FM shifts carrier by plus/minus deviation
// R4 - ten-bit offset word is two's complement
// R5 - offset 156.25 Hz, doubled in high band
// R6 - offset and AFC share one correction
// R7 - both applied through fractional PLL shift
// R8 - RX uses AFC if enabled, else offset
// R9 - AFC frozen after preamble until packet end
// R10 - multi-packet clears AFC at packet end
// R11 - pull-in bounded by unsigned limiter register
// R12 - gear halves feedback per step
// R13 - measure two bits, correct, then settle
// R14 - cycle length field, default four bits
// R15 - zero cycle length gives no correction
// R16 - correction readable, band-scaled per count
// R17 - host sizes preamble for AFC settling
// R18 - bit rate from rate word and prescale
// R19 - host sets prescale below 30 kbps
// R20 - host retunes modulation above 100 kbps
// R21 - rate word affects transmit only
// R22 - rates from slowest to fastest supported
// R23 - high band bit doubles offset scaling
// R24 - register writes take effect directly
`timescale 1ns/1ns
`default_nettype none
module sda_synth_ctrl
    import sda_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic high_band,
    input wire logic rx_mode,
    input wire logic tx_mode,
    input wire logic afc_enable,
    input wire logic multi_packet,
    input wire logic [2:0] afc_gear,
    input wire logic [2:0] afc_cycle_len,
    input wire logic rate_prescale,
    input wire logic tx_data,
    input wire logic rx_bit_tick,
    input wire logic signed [7:0] freq_error,
    input wire logic preamble_det,
    input wire logic packet_end,
    output logic signed [11:0] lo_shift,
    output logic signed [9:0] fm_shift,
    output logic [8:0] deviation_word,
    output logic fm_active,
    output logic tx_bit_tick,
    output logic [1:0] afc_state
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] pull_in_limit, tx_rate_high_byte, tx_rate_low_byte, modulation_control_two;
    logic [7:0] deviation_low_byte, offset_low_byte;
    logic [1:0] offset_high_bits;

    logic wr_limit, wr_rate_hi, wr_rate_lo, wr_mod, wr_dev, wr_ofs_lo, wr_ofs_hi;

    assign wr_limit = reg_write && reg_addr == SDA_ADDR_AFC_LIMIT;
    assign wr_rate_hi = reg_write && reg_addr == SDA_ADDR_RATE_HI;
    assign wr_rate_lo = reg_write && reg_addr == SDA_ADDR_RATE_LO;
    assign wr_mod = reg_write && reg_addr == SDA_ADDR_MOD_CTRL2;
    assign wr_dev = reg_write && reg_addr == SDA_ADDR_DEV_LO;
    assign wr_ofs_lo = reg_write && reg_addr == SDA_ADDR_OFS_LO;
    assign wr_ofs_hi = reg_write && reg_addr == SDA_ADDR_OFS_HI;

    // writes land in one cycle, no commit command
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pull_in_limit <= SDA_RST_AFC_LIMIT;
            tx_rate_high_byte <= SDA_RST_RATE_HI;
            tx_rate_low_byte <= SDA_RST_RATE_LO;
            modulation_control_two <= SDA_RST_MOD_CTRL2;
            deviation_low_byte <= SDA_RST_DEV_LO;
            offset_low_byte <= SDA_RST_OFS_LO;
            offset_high_bits <= SDA_RST_OFS_HI[1:0];
        end else if (ce) begin
            if (wr_limit) begin
                pull_in_limit <= reg_wdata; // R11
            end
            if (wr_rate_hi) begin
                tx_rate_high_byte <= reg_wdata; // R24
            end
            if (wr_rate_lo) begin
                tx_rate_low_byte <= reg_wdata; // R24
            end
            if (wr_mod) begin
                modulation_control_two <= reg_wdata;
            end
            if (wr_dev) begin
                deviation_low_byte <= reg_wdata; // R24
            end
            if (wr_ofs_lo) begin
                offset_low_byte <= reg_wdata; // R24
            end
            if (wr_ofs_hi) begin
                offset_high_bits <= reg_wdata[SDA_OFS_HI_BITS-1:0]; // R4
            end
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    logic signed [7:0] afc_correction;
    logic [7:0] read_mux;
    logic addr_known;

    assign addr_known = reg_addr inside {SDA_ADDR_AFC_LIMIT, SDA_ADDR_AFC_CORR, SDA_ADDR_RATE_HI,
        SDA_ADDR_RATE_LO, [SDA_ADDR_MOD_CTRL2:SDA_ADDR_OFS_HI]};

    always_comb begin
        case (reg_addr)
            SDA_ADDR_AFC_LIMIT: read_mux = pull_in_limit;
            SDA_ADDR_AFC_CORR: read_mux = afc_correction; // R16
            SDA_ADDR_RATE_HI: read_mux = tx_rate_high_byte;
            SDA_ADDR_RATE_LO: read_mux = tx_rate_low_byte;
            SDA_ADDR_MOD_CTRL2: read_mux = modulation_control_two;
            SDA_ADDR_DEV_LO: read_mux = deviation_low_byte;
            SDA_ADDR_OFS_LO: read_mux = offset_low_byte;
            SDA_ADDR_OFS_HI: read_mux = {6'h00, offset_high_bits};
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (ce) begin
            reg_hit <= (reg_read || reg_write) && addr_known;
            if (reg_read) begin
                reg_rdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // deviation and frequency modulation
    // ------------------------------------------------------------
    logic [1:0] mod_type;
    logic signed [10:0] dev_scaled;
    logic signed [9:0] next_fm_shift;

    assign mod_type = modulation_control_two[SDA_MOD_TYPE_LSB +: 2];
    // band bit deliberately absent from the deviation path
    assign deviation_word = {modulation_control_two[SDA_MOD_DEV_MSB_BIT],
                             deviation_low_byte}; // R1 R2
    assign dev_scaled = 11'(deviation_word) <<< SDA_DEV_SHIFT; // R1

    always_comb begin
        next_fm_shift = 10'sh000;
        if (fm_active) begin
            next_fm_shift = tx_data ? dev_scaled[10:1] : -dev_scaled[10:1]; // R3
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fm_active <= 1'b0;
            fm_shift <= 10'sh000;
        end else if (ce) begin
            fm_active <= tx_mode
                && (mod_type == SDA_MODTYPE_FSK || mod_type == SDA_MODTYPE_GFSK); // R3
            fm_shift <= next_fm_shift; // R3
        end
    end

    // ------------------------------------------------------------
    // manual offset and AFC selection
    // ------------------------------------------------------------
    logic signed [9:0] manual_offset_word;
    logic signed [10:0] shared_corr;
    logic use_afc;
    logic afc_run;

    assign manual_offset_word = {offset_high_bits, offset_low_byte}; // R4
    assign use_afc = rx_mode && afc_enable && !tx_mode; // R8
    assign afc_run = use_afc; // R6
    // one shared correction value feeds the PLL
    assign shared_corr = use_afc ? 11'(afc_correction) : 11'(manual_offset_word); // R6 R8

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lo_shift <= 12'sh000;
        end else if (ce) begin
            lo_shift <= high_band ? (12'(shared_corr) <<< 1) : 12'(shared_corr); // R5 R7 R23
        end
    end

    // ------------------------------------------------------------
    // automatic frequency control
    // ------------------------------------------------------------
    sda_afc_loop u_afc (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .enable(afc_run),
        .rx_bit_tick(rx_bit_tick),
        .freq_error(freq_error),
        .preamble_det(preamble_det),
        .packet_end(packet_end),
        .multi_packet(multi_packet),
        .gear(afc_gear),
        .cycle_len(afc_cycle_len),
        .limit(pull_in_limit),
        .correction(afc_correction),
        .state_code(afc_state)
    );

    // ------------------------------------------------------------
    // transmit rate
    // ------------------------------------------------------------
    sda_rate_gen u_rate (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .run(tx_mode), // R21
        .rate_word({tx_rate_high_byte, tx_rate_low_byte}),
        .prescale(rate_prescale),
        .bit_tick(tx_bit_tick)
    );
endmodule
`default_nettype wire

/* core/sda_pkg.sv */
/*
 * Constants shared by the synthesizer deviation, offset, AFC and rate logic.
 * Assumes byte-wide register access with a 7-bit address.
 */
package sda_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] SDA_ADDR_AFC_LIMIT = 7'h2A;
    localparam logic [6:0] SDA_ADDR_AFC_CORR = 7'h2B;
    localparam logic [6:0] SDA_ADDR_RATE_HI = 7'h6E;
    localparam logic [6:0] SDA_ADDR_RATE_LO = 7'h6F;
    localparam logic [6:0] SDA_ADDR_MOD_CTRL2 = 7'h71;
    localparam logic [6:0] SDA_ADDR_DEV_LO = 7'h72;
    localparam logic [6:0] SDA_ADDR_OFS_LO = 7'h73;
    localparam logic [6:0] SDA_ADDR_OFS_HI = 7'h74;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SDA_RST_AFC_LIMIT = 8'h00;
    localparam logic [7:0] SDA_RST_RATE_HI = 8'h0A;
    localparam logic [7:0] SDA_RST_RATE_LO = 8'h3D;
    localparam logic [7:0] SDA_RST_MOD_CTRL2 = 8'h00;
    localparam logic [7:0] SDA_RST_DEV_LO = 8'h20;
    localparam logic [7:0] SDA_RST_OFS_LO = 8'h00;
    localparam logic [7:0] SDA_RST_OFS_HI = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SDA_MOD_DEV_MSB_BIT = 2;
    localparam int SDA_MOD_TYPE_LSB = 0;
    localparam int SDA_OFS_HI_BITS = 2;
    localparam logic [1:0] SDA_MODTYPE_FSK = 2'h2;
    localparam logic [1:0] SDA_MODTYPE_GFSK = 2'h3;

    // ------------------------------------------------------------
    // scaling and timing
    // ------------------------------------------------------------
    localparam int SDA_DEV_SHIFT = 2;
    localparam int SDA_CLOCK_HZ = 20000000;
    localparam int SDA_RATE_REF_HZ = 1000000;
    localparam int SDA_REF_DIV = SDA_CLOCK_HZ / SDA_RATE_REF_HZ;
    localparam int SDA_RATE_BASE_BITS = 16;
    localparam int SDA_RATE_SCALE_BITS = 5;
    localparam int SDA_MEASURE_BITS = 2;
    localparam int SDA_SETTLE_PER_STEP = 2;

    typedef enum logic [1:0] {
        SDA_AFC_OFF = 2'b00,
        SDA_AFC_MEASURE = 2'b01,
        SDA_AFC_SETTLE = 2'b10,
        SDA_AFC_FROZEN = 2'b11
    } sda_afc_state_e;

endpackage

/* core/sda_rate_gen.sv */
/*
 * Transmit bit-rate generator, phase accumulator on a 1 MHz tick.
 * Assumes a 20 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sda_rate_gen
    import sda_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic run,
    input wire logic [15:0] rate_word,
    input wire logic prescale,
    output logic bit_tick
);
    localparam int ACC_W = SDA_RATE_BASE_BITS + SDA_RATE_SCALE_BITS;

    logic [4:0] ref_cnt;
    logic [ACC_W-1:0] acc;
    logic ref_tick;
    logic [ACC_W:0] sum;
    logic carry;

    assign ref_tick = (ref_cnt == 5'(SDA_REF_DIV - 1));
    assign sum = {1'b0, acc} + {{(ACC_W-15){1'b0}}, rate_word};
    // carry out of bit 16, or bit 21 with prescale
    assign carry = prescale ? sum[ACC_W] : sum[SDA_RATE_BASE_BITS];

    // ------------------------------------------------------------
    // reference divider and accumulator
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_cnt <= 5'h00;
            acc <= '0;
            bit_tick <= 1'b0;
        end else if (ce) begin
            ref_cnt <= ref_tick ? 5'h00 : ref_cnt + 5'h01;
            bit_tick <= run && ref_tick && carry; // R18 R22
            if (!run) begin
                acc <= '0;
            end else if (ref_tick) begin
                acc <= prescale ? sum[ACC_W-1:0]
                                : {5'h00, sum[SDA_RATE_BASE_BITS-1:0]}; // R18
            end
        end
    end
endmodule
`default_nettype wire

/* core/sda_afc_loop.sv */
/*
 * AFC loop: measure, correct and settle cycle, freeze and per-packet reset.
 * Assumes demodulator inputs on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sda_afc_loop
    import sda_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic enable,
    input wire logic rx_bit_tick,
    input wire logic signed [7:0] freq_error,
    input wire logic preamble_det,
    input wire logic packet_end,
    input wire logic multi_packet,
    input wire logic [2:0] gear,
    input wire logic [2:0] cycle_len,
    input wire logic [7:0] limit,
    output logic signed [7:0] correction,
    output logic [1:0] state_code
);
    sda_afc_state_e state, next_state;
    logic [4:0] bit_cnt;
    logic signed [9:0] err_sum;
    logic signed [9:0] err_step;
    logic signed [10:0] raw_corr, lim_pos, next_corr;
    logic [4:0] settle_bits;
    logic measure_done, settle_done;

    assign settle_bits = 5'({2'b00, cycle_len} * 5'(SDA_SETTLE_PER_STEP)); // R14
    assign measure_done = rx_bit_tick && (bit_cnt == 5'(SDA_MEASURE_BITS - 1));
    assign settle_done = rx_bit_tick && (bit_cnt >= settle_bits - 5'h01);
    // two-bit error sum over gear shift, 4 bits so gear 7 cannot wrap
    assign err_step = (err_sum + 10'(freq_error)) >>> (4'(gear) + 4'h1); // R12 R13
    assign raw_corr = 11'(correction) + 11'(err_step);
    assign lim_pos = {3'b000, limit};
    assign next_corr = (raw_corr > lim_pos) ? lim_pos :
                       (raw_corr < -lim_pos) ? -lim_pos : raw_corr; // R11
    assign state_code = state;

    // ------------------------------------------------------------
    // cycle sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SDA_AFC_OFF: begin
                if (enable && cycle_len != 3'h0) begin
                    next_state = SDA_AFC_MEASURE;
                end
            end
            SDA_AFC_MEASURE: begin
                if (preamble_det) begin
                    next_state = SDA_AFC_FROZEN; // R9
                end else if (measure_done) begin
                    next_state = SDA_AFC_SETTLE; // R13
                end
            end
            SDA_AFC_SETTLE: begin
                if (preamble_det) begin
                    next_state = SDA_AFC_FROZEN; // R9
                end else if (settle_done) begin
                    next_state = SDA_AFC_MEASURE;
                end
            end
            SDA_AFC_FROZEN: begin
                if (packet_end) begin
                    next_state = SDA_AFC_MEASURE;
                end
            end
            default: next_state = SDA_AFC_OFF;
        endcase
        if (!enable || cycle_len == 3'h0) begin
            next_state = SDA_AFC_OFF; // R15
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= SDA_AFC_OFF;
            bit_cnt <= 5'h00;
            err_sum <= 10'sh000;
            correction <= 8'sh00;
        end else if (ce) begin
            state <= next_state;
            if (state != next_state) begin
                bit_cnt <= 5'h00;
                err_sum <= 10'sh000;
            end else if (rx_bit_tick) begin
                bit_cnt <= bit_cnt + 5'h01;
                if (state == SDA_AFC_MEASURE) begin
                    err_sum <= err_sum + 10'(freq_error);
                end
            end
            if (next_state == SDA_AFC_OFF) begin
                correction <= 8'sh00; // R15
            end else if (state == SDA_AFC_FROZEN && packet_end && multi_packet) begin
                correction <= 8'sh00; // R10
            end else if (state == SDA_AFC_MEASURE && measure_done && !preamble_det) begin
                correction <= next_corr[7:0]; // R13
            end
        end
    end
endmodule
`default_nettype wire

/* test/sda_synth_ctrl_assertions.sv */
/* Port checker for sda_synth_ctrl.
   Assumes the bind below, one clock. */
`timescale 1ns/1ns
`default_nettype none
module sda_synth_ctrl_checker
    import sda_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    input wire logic high_band,
    input wire logic rx_mode,
    input wire logic tx_mode,
    input wire logic afc_enable,
    input wire logic [2:0] afc_cycle_len,
    input wire logic tx_data,
    input wire logic packet_end,
    input wire logic signed [11:0] lo_shift,
    input wire logic signed [9:0] fm_shift,
    input wire logic [8:0] deviation_word,
    input wire logic fm_active,
    input wire logic tx_bit_tick,
    input wire logic [1:0] afc_state
);
    // ------------------------------------------------------------
    // shadow of the manual offset
    // ------------------------------------------------------------
    logic [9:0] ofs;
    wire logic mapped = reg_addr inside {7'h2A, 7'h2B, 7'h6E, 7'h6F, [7'h71:7'h74]};
    wire logic signed [11:0] ofs_ext = {{2{ofs[9]}}, ofs};
    wire logic signed [11:0] dev2 = {2'b00, deviation_word, 1'b0};
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ofs <= 10'h000;
        end else if (ce && reg_write && reg_addr == SDA_ADDR_OFS_LO) begin
            ofs[7:0] <= reg_wdata;
        end else if (ce && reg_write && reg_addr == SDA_ADDR_OFS_HI) begin
            ofs[9:8] <= reg_wdata[1:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_dev_write: assert property (ce && reg_write && reg_addr == SDA_ADDR_DEV_LO
        |=> deviation_word[7:0] == $past(reg_wdata)) else $error("deviation byte not applied");
    a_read_hit: assert property (ce && (reg_read || reg_write) && mapped |=> reg_hit)
        else $error("mapped access without hit");
    a_unmapped_read: assert property (ce && reg_read && !mapped
        |=> !reg_hit && reg_rdata == 8'h00) else $error("unmapped read answered");
    a_fm_polarity: assert property (ce && fm_active && tx_mode |=> !fm_active
        || fm_shift == ($past(tx_data) ? $past(dev2) : -$past(dev2)))
        else $error("fm shift wrong");
    a_freeze_hold: assert property (ce && afc_state == 2'd3 && $past(afc_state) == 2'd3
        && !packet_end && !$past(packet_end) && $stable({high_band, rx_mode, tx_mode, afc_enable})
        |=> $stable(lo_shift)) else $error("frozen correction moved");
    a_cycle_off: assert property (afc_cycle_len == 3'h0 && $past(afc_cycle_len) == 3'h0
        |-> afc_state == 2'd0) else $error("afc runs with zero cycle length");
    a_afc_off: assert property (ce && !(rx_mode && afc_enable && !tx_mode)
        |=> afc_state == 2'd0) else $error("afc active while disabled");
    a_manual_tx: assert property ($past(tx_mode) && $past(ce)
        |-> lo_shift == ($past(high_band) ? $past(ofs_ext) <<< 1 : $past(ofs_ext)))
        else $error("tx offset wrong");
    a_tick_tx: assert property (tx_bit_tick |-> $past(tx_mode) || $past(tx_mode, 2))
        else $error("tx bit tick outside transmit");
    c_frozen: cover property (afc_state == 2'd3);
    c_tick: cover property (tx_bit_tick);
    c_fm_neg: cover property (fm_active && fm_shift < 0);
endmodule
bind sda_synth_ctrl sda_synth_ctrl_checker sda_synth_ctrl_checker_inst (.*);
`default_nettype wire

/* test/sda_remote_tx.sv */
/* Remote transmitter as seen by the demodulator.
   Assumes the bench calls its tasks. */
`timescale 1ns/1ns
`default_nettype none
module sda_remote_tx (
    input wire logic clock,
    output logic rx_bit_tick,
    output logic signed [7:0] freq_error,
    output logic preamble_det,
    output logic packet_end
);
    initial begin
        rx_bit_tick = 1'b0;
        freq_error = 8'h00;
        preamble_det = 1'b0;
        packet_end = 1'b0;
    end
    // n bits of eight clocks
    task automatic send(input int n, input logic signed [7:0] e);
        for (int i = 0; i < n; i++) begin
            repeat (7) @(posedge clock);
            freq_error <= e;
            rx_bit_tick <= 1'b1;
            @(posedge clock);
            rx_bit_tick <= 1'b0;
            freq_error <= ~e;
        end
    endtask
    task automatic mark(input logic pre);
        @(posedge clock);
        preamble_det <= pre;
        packet_end <= !pre;
        @(posedge clock);
        preamble_det <= 1'b0;
        packet_end <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* test/sda_synth_ctrl_bench.sv */
/* Bench for sda_synth_ctrl.
   Assumes the bound checker and the remote model. */
`timescale 1ns/1ns
`default_nettype none
module sda_synth_ctrl_bench
    import sda_pkg::*;
;
    typedef struct {
        logic [2:0] gear;
        logic hb;
        logic signed [7:0] err;
        logic [7:0] lim;
        logic [7:0] corr;
    } sda_row_s;
    sda_row_s rows [7] = '{'{3'h0, 1'b0, 8'h08, 8'h7F, 8'h08}, '{3'h1, 1'b0, 8'h08, 8'h7F, 8'h04},
        '{3'h2, 1'b1, 8'h08, 8'h7F, 8'h02}, '{3'h0, 1'b0, 8'hF8, 8'h7F, 8'hF8},
        '{3'h0, 1'b1, 8'h28, 8'h10, 8'h10}, '{3'h0, 1'b0, 8'hD8, 8'h10, 8'hF0},
        '{3'h7, 1'b0, 8'h08, 8'h7F, 8'h00}};
    logic [6:0] rst_addr [8] = '{7'h2A, 7'h2B, 7'h6E, 7'h6F, 7'h71, 7'h72, 7'h73, 7'h74};
    logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h0A, 8'h3D, 8'h00, 8'h20, 8'h00, 8'h00};
    logic clock, rstn = 1'b0, ce = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic high_band = 1'b0, rx_mode = 1'b1, tx_mode = 1'b0, afc_enable = 1'b0;
    logic multi_packet = 1'b0, rate_prescale = 1'b0, tx_data = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [2:0] afc_gear = 3'h0, afc_cycle_len = 3'h1;
    logic [7:0] reg_rdata;
    logic reg_hit, rx_bit_tick, preamble_det, packet_end, fm_active, tx_bit_tick;
    logic signed [7:0] freq_error;
    logic signed [11:0] lo_shift;
    logic signed [9:0] fm_shift;
    logic [8:0] deviation_word;
    logic [1:0] afc_state;
    int errors = 0, total_checks = 0;
    sda_synth_ctrl sda_synth_ctrl_inst (.*);
    sda_remote_tx sda_remote_tx_inst (.*);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic h);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk("reg_rdata", e, reg_rdata);
        chk("reg_hit", h, reg_hit);
    endtask
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask
    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
    endtask
    // clocks between two tx bit ticks
    task automatic gap(input int exp);
        int n;
        repeat (2) @(posedge tx_bit_tick);
        @(negedge clock);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (tx_bit_tick !== 1'b1 && n < 4000);
        chk("tick_gap", exp, n);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int e, n;
        do_reset();
        foreach (rows[i]) begin
            @(posedge clock);
            afc_enable <= 1'b0;
            high_band <= rows[i].hb;
            afc_gear <= rows[i].gear;
            wr(SDA_ADDR_AFC_LIMIT, rows[i].lim);
            @(posedge clock);
            afc_enable <= 1'b1;
            sda_remote_tx_inst.send(2, rows[i].err);
            rd(SDA_ADDR_AFC_CORR, rows[i].corr, 1'b1);
            e = $signed(rows[i].corr);
            chk("lo_shift", rows[i].hb ? e * 2 : e, lo_shift);
        end
        @(posedge clock);
        afc_enable <= 1'b0;
        afc_gear <= 3'h0;
        high_band <= 1'b0;
        wr(SDA_ADDR_AFC_LIMIT, 8'h7F);
        @(posedge clock);
        afc_enable <= 1'b1;
        sda_remote_tx_inst.send(40, 8'h04);
        sda_remote_tx_inst.mark(1'b1);
        @(negedge clock);
        chk("afc_state", SDA_AFC_FROZEN, afc_state);
        rd(SDA_ADDR_AFC_CORR, 8'h28, 1'b1);
        sda_remote_tx_inst.send(8, 8'h28);
        rd(SDA_ADDR_AFC_CORR, 8'h28, 1'b1);
        sda_remote_tx_inst.mark(1'b0);
        rd(SDA_ADDR_AFC_CORR, 8'h28, 1'b1);
        sda_remote_tx_inst.mark(1'b1);
        @(posedge clock);
        multi_packet <= 1'b1;
        sda_remote_tx_inst.mark(1'b0);
        rd(SDA_ADDR_AFC_CORR, 8'h00, 1'b1);
        @(posedge clock);
        afc_enable <= 1'b0;
        afc_cycle_len <= 3'h0;
        @(posedge clock);
        afc_enable <= 1'b1;
        sda_remote_tx_inst.send(4, 8'h28);
        rd(SDA_ADDR_AFC_CORR, 8'h00, 1'b1);
        chk("afc_state", SDA_AFC_OFF, afc_state);
        @(posedge clock);
        afc_enable <= 1'b0;
        afc_cycle_len <= 3'h1;
        high_band <= 1'b1;
        wr(SDA_ADDR_OFS_LO, 8'h60);
        wr(SDA_ADDR_OFS_HI, 8'hFF);
        rd(SDA_ADDR_OFS_HI, 8'h03, 1'b1);
        chk("lo_shift", -320, lo_shift);
        @(posedge clock);
        high_band <= 1'b0;
        afc_enable <= 1'b1;
        tx_mode <= 1'b1;
        rx_mode <= 1'b0;
        settle();
        chk("lo_shift", -160, lo_shift);
        wr(SDA_ADDR_MOD_CTRL2, 8'h04);
        wr(SDA_ADDR_DEV_LO, 8'h40);
        @(negedge clock);
        chk("deviation_word", 9'h140, deviation_word);
        chk("fm_active", 1'b0, fm_active);
        wr(SDA_ADDR_MOD_CTRL2, 8'h02);
        @(posedge clock);
        tx_data <= 1'b1;
        settle();
        chk("fm_shift", 128, fm_shift);
        @(posedge clock);
        tx_data <= 1'b0;
        high_band <= 1'b1;
        settle();
        chk("fm_shift", -128, fm_shift);
        chk("fm_active", 1'b1, fm_active);
        rd(7'h10, 8'h00, 1'b0);
        wr(SDA_ADDR_RATE_HI, 8'h40);
        wr(SDA_ADDR_RATE_LO, 8'h00);
        gap(80);
        @(posedge clock);
        rate_prescale <= 1'b1;
        gap(2560);
        @(posedge clock);
        tx_mode <= 1'b0;
        n = 0;
        repeat (1400) begin
            @(negedge clock);
            if (tx_bit_tick === 1'b1) n++;
        end
        chk("tx_ticks", 0, n);
        do_reset();
        wr(SDA_ADDR_AFC_CORR, 8'hFF);
        foreach (rst_addr[i]) rd(rst_addr[i], rst_val[i], 1'b1);
        chk("deviation_word", 9'h020, deviation_word);
        chk("lo_shift", 0, lo_shift);
        conclude();
    end
endmodule
`default_nettype wire
